// *** gxc_pkg.sv ***
// Package with register map, field layout and types for gesture exit control
//
// Notes on behaviour
// - Gesture end: sum of unmasked direction diodes below exit level.
// - Session ends on a gesture end only when the exit persistence count is also met.
// - Exit level zero never ends a session; only clearing mode does.
// - FIFO datasets at the level count raise the irq if enabled.
// - FIFO level field 0,1,2,3 selects 1,4,8,16 datasets.
// - Mask bit 0 drops right, 1 left, 2 down, 3 up.
// - Mask all zeros sums every diode; all ones sums none.
// - Session ends when consecutive gesture ends reach the count.
// - Persistence field 0,1,2,3 selects 1st, 2nd, 4th, 7th end.
// - Session starts on near result at entry level, no persistence.
package gxc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] EXIT_LEVEL_ADDR  = 8'ha1;
    localparam logic [7:0] CONFIG_ONE_ADDR  = 8'ha2;
    localparam logic [7:0] EXIT_LEVEL_RESET = 8'h00;
    localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;

    // ****************************************************************
    // Field positions in the second configuration register
    // ****************************************************************
    localparam int FIFO_LVL_HI = 7;
    localparam int FIFO_LVL_LO = 6;
    localparam int MASK_HI     = 5;
    localparam int MASK_LO     = 2;
    localparam int PERSIST_HI  = 1;
    localparam int PERSIST_LO  = 0;

    // Mask bit positions within the mask field
    localparam int MASK_RIGHT = 0;
    localparam int MASK_LEFT  = 1;
    localparam int MASK_DOWN  = 2;
    localparam int MASK_UP    = 3;

    // Dataset counts selected by the FIFO level field
    localparam logic [5:0] FIFO_CNT_0 = 6'h01;
    localparam logic [5:0] FIFO_CNT_1 = 6'h04;
    localparam logic [5:0] FIFO_CNT_2 = 6'h08;
    localparam logic [5:0] FIFO_CNT_3 = 6'h10;

    // Consecutive gesture-end counts selected by the persistence field
    localparam logic [2:0] PERS_CNT_0 = 3'h1;
    localparam logic [2:0] PERS_CNT_1 = 3'h2;
    localparam logic [2:0] PERS_CNT_2 = 3'h4;
    localparam logic [2:0] PERS_CNT_3 = 3'h7;

    // One detection cycle of the four direction diodes
    typedef struct packed {
        logic [7:0] up;
        logic [7:0] down;
        logic [7:0] left;
        logic [7:0] right;
    } gxc_diodes_t;

    // Register write/read request from the serial host interface
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gxc_reg_req_t;

    typedef enum logic [0:0] {
        GXC_IDLE   = 1'b0,
        GXC_ACTIVE = 1'b1
    } gxc_state_t;

endpackage

// *** gxc_exit_ctrl.sv ***
// Gesture session entry/exit decision and FIFO level interrupt logic
`timescale 1ns/1ns
module gxc_exit_ctrl (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // Register port from the serial host interface
    input  wire gxc_pkg::gxc_reg_req_t reg_req,
    output logic [7:0]                reg_rdata_r,
    // Gesture mode bit and entry inputs
    input  wire logic                 gesture_mode,
    input  wire logic                 near_valid,
    input  wire logic [7:0]           near_result,
    input  wire logic [7:0]           entry_level,
    // Direction diode data, one pulse per detection cycle
    input  wire logic                 cycle_done,
    input  wire gxc_pkg::gxc_diodes_t four_direction_diodes,
    // FIFO status
    input  wire logic [5:0]           fifo_level,
    input  wire logic                 fifo_irq_enable,
    // Results
    output logic                      gesture_session_active,
    output logic                      exit_pulse_r,
    output logic                      fifo_irq_r
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************

    // Dataset count that raises the FIFO interrupt
    function automatic logic [5:0] fifo_target(input logic [1:0] fld);
        case (fld)
            2'h0:    fifo_target = gxc_pkg::FIFO_CNT_0;
            2'h1:    fifo_target = gxc_pkg::FIFO_CNT_1;
            2'h2:    fifo_target = gxc_pkg::FIFO_CNT_2;
            default: fifo_target = gxc_pkg::FIFO_CNT_3;
        endcase
    endfunction

    // Consecutive gesture-end count that ends the session
    function automatic logic [2:0] persist_target(input logic [1:0] fld);
        case (fld)
            2'h0:    persist_target = gxc_pkg::PERS_CNT_0;
            2'h1:    persist_target = gxc_pkg::PERS_CNT_1;
            2'h2:    persist_target = gxc_pkg::PERS_CNT_2;
            default: persist_target = gxc_pkg::PERS_CNT_3;
        endcase
    endfunction

    // Sum of the diodes whose mask bit is clear
    function automatic logic [9:0] masked_sum(input gxc_pkg::gxc_diodes_t d,
                                              input logic [3:0] m);
        logic [9:0] s;
        s = 10'h000;
        if (!m[gxc_pkg::MASK_RIGHT]) s = s + {2'h0, d.right};
        if (!m[gxc_pkg::MASK_LEFT])  s = s + {2'h0, d.left};
        if (!m[gxc_pkg::MASK_DOWN])  s = s + {2'h0, d.down};
        if (!m[gxc_pkg::MASK_UP])    s = s + {2'h0, d.up};
        masked_sum = s; // Zero mask sums all, full mask none
    endfunction

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [7:0] exit_level_r, exit_level_nxt;
    logic [7:0] config_one_r, config_one_nxt;
    logic [7:0] reg_rdata_nxt;
    logic [1:0] fifo_irq_level;
    logic [3:0] exit_channel_mask;
    logic [1:0] exit_persist_field;

    assign fifo_irq_level     = config_one_r[gxc_pkg::FIFO_LVL_HI:
                                             gxc_pkg::FIFO_LVL_LO];
    assign exit_channel_mask  = config_one_r[gxc_pkg::MASK_HI:
                                             gxc_pkg::MASK_LO];
    assign exit_persist_field = config_one_r[gxc_pkg::PERSIST_HI:
                                             gxc_pkg::PERSIST_LO];

    // Writes store, reads return the stored value one cycle later
    always_comb begin
        exit_level_nxt = exit_level_r;
        config_one_nxt = config_one_r;
        if (reg_req.wr && reg_req.addr == gxc_pkg::EXIT_LEVEL_ADDR) begin
            exit_level_nxt = reg_req.wdata;
        end
        if (reg_req.wr && reg_req.addr == gxc_pkg::CONFIG_ONE_ADDR) begin
            config_one_nxt = reg_req.wdata;
        end
        case (reg_req.addr)
            gxc_pkg::EXIT_LEVEL_ADDR: reg_rdata_nxt = exit_level_r;
            gxc_pkg::CONFIG_ONE_ADDR: reg_rdata_nxt = config_one_r;
            default:                  reg_rdata_nxt = gxc_pkg::UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            exit_level_r <= gxc_pkg::EXIT_LEVEL_RESET;
            config_one_r <= gxc_pkg::CONFIG_ONE_RESET;
            reg_rdata_r  <= gxc_pkg::UNMAPPED_READ;
        end else begin
            exit_level_r <= exit_level_nxt;
            config_one_r <= config_one_nxt;
            reg_rdata_r  <= reg_rdata_nxt;
        end
    end

    // ****************************************************************
    // Session state machine and gesture-end persistence
    // ****************************************************************
    gxc_pkg::gxc_state_t state_r, state_nxt;
    logic [2:0] exit_persist_count_r, exit_persist_count_nxt;
    logic       exit_pulse_nxt;
    logic       session_active_nxt;
    logic       gesture_end;
    logic [9:0] exit_sum;

    assign exit_sum = masked_sum(four_direction_diodes, exit_channel_mask);
    // Zero level can never be undercut, so a session stays open
    assign gesture_end = (exit_level_r != 8'h00) &&
                         (exit_sum < {2'h0, exit_level_r});
    // Entry ignores proximity persistence: one result at or above level suffices
    always_comb begin
        state_nxt              = state_r;
        exit_persist_count_nxt = exit_persist_count_r;
        exit_pulse_nxt         = 1'b0;
        case (state_r)
            gxc_pkg::GXC_IDLE: begin
                exit_persist_count_nxt = 3'h0;
                if (gesture_mode && near_valid &&
                    near_result >= entry_level) begin
                    state_nxt = gxc_pkg::GXC_ACTIVE;
                end
            end
            gxc_pkg::GXC_ACTIVE: begin
                if (!gesture_mode) begin
                    state_nxt = gxc_pkg::GXC_IDLE;
                end else if (cycle_done) begin
                    if (!gesture_end) begin
                        exit_persist_count_nxt = 3'h0;
                    end else if (exit_persist_count_r + 3'h1 >=
                                 persist_target(exit_persist_field)) begin
                        state_nxt      = gxc_pkg::GXC_IDLE;
                        exit_pulse_nxt = 1'b1;
                    end else begin
                        exit_persist_count_nxt = exit_persist_count_r + 3'h1;
                    end
                end
            end
            default: state_nxt = gxc_pkg::GXC_IDLE;
        endcase
        // Output flop follows the next state, so no decoder sits on the pin
        session_active_nxt = (state_nxt == gxc_pkg::GXC_ACTIVE);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r              <= gxc_pkg::GXC_IDLE;
            exit_persist_count_r <= 3'h0;
            exit_pulse_r         <= 1'b0;
            gesture_session_active <= 1'b0;
        end else begin
            state_r              <= state_nxt;
            exit_persist_count_r <= exit_persist_count_nxt;
            exit_pulse_r         <= exit_pulse_nxt;
            gesture_session_active <= session_active_nxt;
        end
    end

    // ****************************************************************
    // FIFO level interrupt
    // ****************************************************************
    logic fifo_irq_nxt;

    // Level interrupt: follows the FIFO, so draining it drops the line
    always_comb begin
        fifo_irq_nxt = fifo_irq_enable &&
                       (fifo_level >= fifo_target(fifo_irq_level));
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fifo_irq_r <= 1'b0;
        end else begin
            fifo_irq_r <= fifo_irq_nxt;
        end
    end

endmodule

// *** gxc_exit_ctrl_checker.sv ***
// Checker for gesture exit and FIFO interrupt control
`timescale 1ns/1ns
module gxc_exit_checker (
    // Clock, reset and register port
    input wire logic                  clk,
    input wire logic                  srst,
    input wire gxc_pkg::gxc_reg_req_t reg_req,
    input wire logic [7:0]            reg_rdata_r,
    // Session and FIFO
    input wire logic                  gesture_mode,
    input wire logic                  near_valid,
    input wire logic [7:0]            near_result,
    input wire logic [7:0]            entry_level,
    input wire logic                  cycle_done,
    input wire gxc_pkg::gxc_diodes_t  four_direction_diodes,
    input wire logic [5:0]            fifo_level,
    input wire logic                  fifo_irq_enable,
    input wire logic                  gesture_session_active,
    input wire logic                  exit_pulse_r,
    input wire logic                  fifo_irq_r
);
    // ********
    // Shadow state
    // ********
    logic [7:0] lvl_r;
    logic [7:0] cfg_r;
    logic [5:0] tgt;
    wire        act = gesture_session_active;
    wire        irq_exp = fifo_irq_enable && fifo_level >= tgt;
    // The block's registers are hidden, so mirror the writes here
    always_ff @(posedge clk) begin
        if (srst) {lvl_r, cfg_r} <= 16'h0000;
        else if (reg_req.wr && reg_req.addr == 8'ha1) lvl_r <= reg_req.wdata;
        else if (reg_req.wr && reg_req.addr == 8'ha2) cfg_r <= reg_req.wdata;
    end
    // Field 0 means one dataset, the others double from four
    assign tgt = (cfg_r[7:6] == 2'h0) ? 6'h01 : (6'h02 << cfg_r[7:6]);
    // Reference end count: mask bits drop right, left, down, up in order
    logic [9:0] sum;
    logic [2:0] need;
    logic [2:0] ends_r;
    assign sum = (cfg_r[2] ? 10'h000 : {2'h0, four_direction_diodes.right})
               + (cfg_r[3] ? 10'h000 : {2'h0, four_direction_diodes.left})
               + (cfg_r[4] ? 10'h000 : {2'h0, four_direction_diodes.down})
               + (cfg_r[5] ? 10'h000 : {2'h0, four_direction_diodes.up});
    // Persistence field 3 asks for the seventh end, not the eighth
    assign need = (cfg_r[1:0] == 2'h3) ? 3'h7 : (3'h1 << cfg_r[1:0]);
    wire        dend = gesture_mode && cycle_done && lvl_r != 8'h00
                       && sum < {2'h0, lvl_r};
    // Consecutive ends; cleared while idle and on a non-end cycle
    always_ff @(posedge clk) begin
        if (srst || !act) ends_r <= 3'h0;
        else if (dend) ends_r <= ends_r + 3'h1;
        else if (cycle_done && gesture_mode) ends_r <= 3'h0;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    property p_unmap; reg_req.addr != 8'ha1 && reg_req.addr != 8'ha2
        |=> reg_rdata_r == 8'h00; endproperty
    property p_rdback; !reg_req.wr && reg_req.addr == 8'ha1
        |=> reg_rdata_r == $past(lvl_r); endproperty
    property p_enter; !act && gesture_mode && near_valid
        && near_result >= entry_level |=> act; endproperty
    property p_zero; act && gesture_mode && lvl_r == 8'h00 |=> act; endproperty
    property p_modeoff; act && !gesture_mode |=> !act && !exit_pulse_r;
    endproperty
    property p_cause; exit_pulse_r |-> $past(cycle_done) && $past(act)
        && $past(lvl_r) != 8'h00 && !act; endproperty
    property p_pulse; exit_pulse_r |=> !exit_pulse_r; endproperty
    property p_fifo; 1'b1 |=> fifo_irq_r == $past(irq_exp); endproperty
    sequence s_last_end;
        act && dend && (ends_r + 3'h1 >= need);
    endsequence
    sequence s_exit;
        exit_pulse_r && !act;
    endsequence
    property p_exit; s_last_end |=> s_exit; endproperty
    property p_stay; act && cycle_done && gesture_mode
        && !(dend && ends_r + 3'h1 >= need) |=> act && !exit_pulse_r;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("bad unmapped read");
    a_rdback: assert property (p_rdback)
        else $error("bad readback");
    a_enter: assert property (p_enter)
        else $error("no entry");
    a_zero: assert property (p_zero)
        else $error("exit at level 0");
    a_modeoff: assert property (p_modeoff)
        else $error("mode off");
    a_cause: assert property (p_cause)
        else $error("stray exit");
    a_pulse: assert property (p_pulse)
        else $error("long pulse");
    a_fifo: assert property (p_fifo)
        else $error("bad fifo irq");
    a_exit: assert property (p_exit)
        else $error("missed persistence exit");
    a_stay: assert property (p_stay)
        else $error("early exit");
endmodule
bind gxc_exit_ctrl gxc_exit_checker u_chk (
    .clk, .srst, .reg_req, .reg_rdata_r, .gesture_mode, .near_valid,
    .near_result, .entry_level, .cycle_done, .four_direction_diodes,
    .fifo_level, .fifo_irq_enable,
    .gesture_session_active, .exit_pulse_r, .fifo_irq_r);

// *** gxc_host_model.sv ***
// Host model issuing register writes and reads
`timescale 1ns/1ns
module gxc_host_model (
    // Clock and register port
    input  wire logic             clk,
    output gxc_pkg::gxc_reg_req_t reg_req,
    input  wire logic [7:0]       reg_rdata_r
);
    initial reg_req = '0;
    // A released port shows inverted values, never a stale copy
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) reg_req <= '{1'b1, a, d};
        @(posedge clk) reg_req <= '{1'b0, ~a, ~d};
    endtask
    // Read data is registered, so take it two edges after driving the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) reg_req <= '{1'b0, a, 8'h00};
        repeat (2) @(posedge clk);
        d = reg_rdata_r;
    endtask
endmodule

// *** gxc_exit_ctrl_test.sv ***
// Self-checking testbench for gesture exit and FIFO interrupt control
`timescale 1ns/1ns
module gxc_exit_ctrl_test;
    logic                  clk, srst, gm, nv, cd, fen, act, ep, irq;
    logic [7:0]            nr, rv, rdata, el;
    logic [5:0]            fl;
    gxc_pkg::gxc_diodes_t  dio;
    gxc_pkg::gxc_reg_req_t req;
    int                    failures, samples_checked;
    gxc_host_model host (.clk(clk), .reg_req(req), .reg_rdata_r(rdata));
    gxc_exit_ctrl DUT (.clk(clk), .srst(srst), .reg_req(req),
        .reg_rdata_r(rdata), .gesture_mode(gm), .near_valid(nv),
        .near_result(nr), .entry_level(el), .cycle_done(cd),
        .four_direction_diodes(dio), .fifo_level(fl), .fifo_irq_enable(fen),
        .gesture_session_active(act), .exit_pulse_r(ep), .fifo_irq_r(irq));
    // ********
    // Clock, compare and closing
    // ********
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Start a session: a near result one below entry must not start it
    task automatic enter;
        @(posedge clk) {nv, nr} <= {1'b1, el - 8'h01};
        @(posedge clk) nr <= el;
        @(negedge clk) chk({7'h00, act}, 8'h00);
        @(posedge clk) nv <= 1'b0;
        @(negedge clk) chk({7'h00, act}, 8'h01);
    endtask
    task automatic cyc(input logic [31:0] d, input logic [1:0] e);
        @(posedge clk) {cd, dio} <= {1'b1, d};
        @(posedge clk) cd <= 1'b0;
        @(negedge clk) chk({6'h00, act, ep}, {6'h00, e});
    endtask
    task automatic drop;
        @(posedge clk) gm <= 1'b0;
        @(posedge clk) gm <= 1'b1;
        @(negedge clk) chk({6'h00, act, ep}, 8'h00);
    endtask
    task automatic fset(input logic [5:0] l, input logic en, input logic e);
        @(posedge clk) {fl, fen} <= {l, en};
        @(posedge clk);
        @(negedge clk) chk({7'h00, irq}, {7'h00, e});
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_regs;
        host.rd(8'ha1, rv);
        chk(rv, 8'h00);
        host.wr(8'ha1, 8'h5a);
        host.wr(8'ha2, 8'hc3);
        host.rd(8'ha1, rv);
        chk(rv, 8'h5a);
        host.rd(8'ha2, rv);
        chk(rv, 8'hc3);
        host.rd(8'ha0, rv);
        chk(rv, 8'h00);
        $display("regs done");
    endtask
    task automatic t_fifo;
        logic [5:0] tg [4] = '{6'h01, 6'h04, 6'h08, 6'h10};
        for (int f = 0; f < 4; f++) begin
            host.wr(8'ha2, {f[1:0], 6'h00});
            fset(tg[f] - 6'h01, 1'b1, 1'b0);
            fset(tg[f], 1'b1, 1'b1);
            fset(tg[f], 1'b0, 1'b0);
        end
        $display("fifo done");
    endtask
    // One loud cycle in the middle must restart the end count
    task automatic t_pers;
        int n [4] = '{1, 2, 4, 7};
        host.wr(8'ha1, 8'h50);
        for (int p = 0; p < 4; p++) begin
            host.wr(8'ha2, {6'h00, p[1:0]});
            enter();
            repeat (n[p] - 1) cyc(32'h01010101, 2'b10);
            cyc(32'h40404040, 2'b10);
            repeat (n[p] - 1) cyc(32'h01010101, 2'b10);
            cyc(32'h01010101, 2'b01);
        end
        $display("persistence done");
    endtask
    // Diode values differ so every mask gives its own sum; 0x50 is a tie
    task automatic t_mask;
        logic [3:0] m [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'hf};
        logic [9:0] s;
        logic [1:0] e;
        @(posedge clk) el <= 8'hc0;
        for (int i = 0; i < 8; i++) begin
            s = (m[i][0] ? 10'h0 : 10'h08) + (m[i][1] ? 10'h0 : 10'h10)
              + (m[i][2] ? 10'h0 : 10'h20) + (m[i][3] ? 10'h0 : 10'h40);
            host.wr(8'ha2, {2'b00, m[i], 2'b00});
            enter();
            e = (s < 10'h050) ? 2'b01 : 2'b10;
            cyc(32'h40201008, e);
            if (act === 1'b1) drop();
        end
        host.wr(8'ha1, 8'h00);
        host.wr(8'ha2, 8'h3c);
        enter();
        cyc(32'h00000000, 2'b10);
        drop();
        $display("mask and zero level done");
    endtask
    initial begin
        {gm, nv, nr, cd, dio, fl, fen, failures, samples_checked} = '0;
        el = 8'h80;
        srst = 1'b1;
        repeat (5) @(posedge clk);
        {srst, gm} <= 2'b01;
        t_regs();
        t_fifo();
        t_pers();
        t_mask();
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule
